// ==== hdl/sbsr_pkg.sv ====
package sbsr_pkg;

   // Status byte bit positions
   localparam int BIT_MEAS = 0;
   localparam int BIT_UNUSED = 1;
   localparam int BIT_ERR = 2;
   localparam int BIT_QUES = 3;
   localparam int BIT_MSG = 4;
   localparam int BIT_STD = 5;
   localparam int BIT_RQS = 6;
   localparam int BIT_OPER = 7;

   localparam int EVT_W = 16;
   localparam logic [7:0] ENABLE_RESET = 8'h00;
   // Summary bits that may take part in the master summary (B1 and B6 never do)
   localparam logic [7:0] SUMMARY_MASK = 8'hBD;

   typedef struct packed {
      logic [15:0] event_bits;
      logic [15:0] enable_bits;
   } sbsr_evset_t;

   typedef struct packed {
      logic [7:0] enable_reg;
      logic [7:0] summary_reg;
      logic master_reg;
      logic rqs_reg;
      logic srq_reg;
      logic [7:0] poll_byte_reg;
      logic [7:0] query_byte_reg;
      logic poll_valid_reg;
      logic query_valid_reg;
   } sbsr_state_t;

endpackage

// ==== hdl/sbsr_summary.sv ====
// Summary message of one event register set
module sbsr_summary (
   input wire logic clk,
   input wire logic rst,
   input wire sbsr_pkg::sbsr_evset_t evset,
   output logic summary
);

   logic summary_reg;
   logic summary_next;

   always_comb begin
      summary_next = |(evset.event_bits & evset.enable_bits);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         summary_reg <= 1'b0;
      end else begin
         summary_reg <= summary_next;
      end
   end

   assign summary = summary_reg;

   sum_follows_a: assert property (@(posedge clk) disable iff (rst)
      ##1 (summary == $past(|(evset.event_bits & evset.enable_bits))))
      else $error("event set summary does not follow enabled events");

endmodule

// ==== hdl/sbsr_status_byte.sv ====
// How it works
// - Summary bits never latch; they follow their sources.
// - Clearing the standard event register drops bit B5.
// - B0 is the measurement summary.
// - B2 is set while the error queue is not empty.
// - B3 is the questionable summary.
// - B4 is set while the output queue holds a response.
// - B5 is the standard event summary.
// - B7 is the operation summary.
// - Enabled summary bits are ORed into B6.
// - B6 is request flag on serial poll, master summary on query.
// - Enable register takes any value 0 to 255 and reads back.
// - Enable register clears at power-on.
// - Clear-status and preset leave the enable register alone.
// - Rising enabled summary bit sets B6 and asserts service request.
// - Completed serial poll clears the request flag.
// - Still-pending event raises no new request after a poll; only a new rising bit does.
// - Poll leaves master summary; it drops only when all enabled bits clear.
// - Serial poll returns the status byte as poll byte.
// - At power-on all summaries start at zero.
// - Each event set summary is OR of event AND enable.
module sbsr_status_byte (
   input wire logic clk,
   input wire logic rst,
   input wire sbsr_pkg::sbsr_evset_t meas_set,
   input wire sbsr_pkg::sbsr_evset_t ques_set,
   input wire sbsr_pkg::sbsr_evset_t std_set,
   input wire sbsr_pkg::sbsr_evset_t oper_set,
   input wire logic error_available,
   input wire logic message_available,
   input wire logic enable_write,
   input wire logic [7:0] enable_wdata,
   input wire logic clear_status_command,
   input wire logic preset_command,
   input wire logic status_byte_query,
   input wire logic serial_poll,
   output logic [7:0] request_enable_mask,
   output logic [7:0] summary_status_byte,
   output logic master_summary,
   output logic service_request,
   output logic [7:0] poll_byte,
   output logic poll_valid,
   output logic [7:0] query_byte,
   output logic query_valid
);

   ////////////////////////////////////////////////////////////////////////////
   sbsr_pkg::sbsr_evset_t sets [4];
   logic [3:0] set_summary;
   sbsr_pkg::sbsr_state_t st_reg;
   sbsr_pkg::sbsr_state_t st_next;
   logic [7:0] live_byte;
   logic [7:0] enabled_now;
   logic [7:0] enabled_prev;
   logic master_now;
   logic rise;

   assign sets[0] = meas_set;
   assign sets[1] = ques_set;
   assign sets[2] = std_set;
   assign sets[3] = oper_set;

   for (genvar i = 0; i < 4; i++) begin : g_sum
      sbsr_summary u_sum (
         .clk(clk),
         .rst(rst),
         .evset(sets[i]),
         .summary(set_summary[i])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      live_byte = 8'h00;
      live_byte[sbsr_pkg::BIT_MEAS] = set_summary[0];
      live_byte[sbsr_pkg::BIT_ERR] = error_available;
      live_byte[sbsr_pkg::BIT_QUES] = set_summary[1];
      live_byte[sbsr_pkg::BIT_MSG] = message_available;
      live_byte[sbsr_pkg::BIT_STD] = set_summary[2];
      live_byte[sbsr_pkg::BIT_OPER] = set_summary[3];
      // Bit 6 of the mask is dropped so B6 cannot feed itself
      enabled_now = live_byte & st_reg.enable_reg & sbsr_pkg::SUMMARY_MASK;
      enabled_prev = st_reg.summary_reg & st_reg.enable_reg & sbsr_pkg::SUMMARY_MASK;
      master_now = |enabled_now;
      // Enabling a bit that is already set lifts master but raises no new request
      rise = |(enabled_now & ~enabled_prev);
   end

   always_comb begin
      st_next = st_reg;
      st_next.summary_reg = live_byte;
      st_next.master_reg = master_now;
      st_next.poll_valid_reg = 1'b0;
      st_next.query_valid_reg = 1'b0;
      // Clear-status and preset have no path to the mask
      if (enable_write) begin
         st_next.enable_reg = enable_wdata;
      end
      if (serial_poll) begin
         st_next.poll_byte_reg = st_reg.summary_reg;
         st_next.poll_byte_reg[sbsr_pkg::BIT_RQS] = st_reg.rqs_reg;
         st_next.poll_valid_reg = 1'b1;
         st_next.rqs_reg = 1'b0;
      end
      // A new rising bit in the poll cycle wins over the clear
      if (rise) begin
         st_next.rqs_reg = 1'b1;
      end
      st_next.srq_reg = st_next.rqs_reg;
      if (status_byte_query) begin
         st_next.query_byte_reg = st_reg.summary_reg;
         st_next.query_byte_reg[sbsr_pkg::BIT_RQS] = st_reg.master_reg;
         st_next.query_valid_reg = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg <= '0;
         st_reg.enable_reg <= sbsr_pkg::ENABLE_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign request_enable_mask = st_reg.enable_reg;
   always_comb begin
      summary_status_byte = st_reg.summary_reg;
      summary_status_byte[sbsr_pkg::BIT_RQS] = st_reg.master_reg;
   end
   assign master_summary = st_reg.master_reg;
   assign service_request = st_reg.srq_reg;
   assign poll_byte = st_reg.poll_byte_reg;
   assign poll_valid = st_reg.poll_valid_reg;
   assign query_byte = st_reg.query_byte_reg;
   assign query_valid = st_reg.query_valid_reg;

   ////////////////////////////////////////////////////////////////////////////
   sequence s_poll;
      serial_poll && !rise;
   endsequence

   sequence s_req_cleared;
      ##1 !service_request;
   endsequence

   err_mirror_a: assert property (@(posedge clk) disable iff (rst)
      ##1 summary_status_byte[sbsr_pkg::BIT_ERR] == $past(error_available))
      else $error("error available bit does not follow queue");

   msg_mirror_a: assert property (@(posedge clk) disable iff (rst)
      ##1 summary_status_byte[sbsr_pkg::BIT_MSG] == $past(message_available))
      else $error("message available bit does not follow queue");

   unused_zero_a: assert property (@(posedge clk) disable iff (rst)
      summary_status_byte[sbsr_pkg::BIT_UNUSED] == 1'b0)
      else $error("unused bit one is set");

   // Master is reduced with the mask that stood one cycle before it shows
   master_or_a: assert property (@(posedge clk) disable iff (rst)
      master_summary == |(summary_status_byte & $past(request_enable_mask) & sbsr_pkg::SUMMARY_MASK))
      else $error("master summary is not the OR of enabled bits");

   mask_write_a: assert property (@(posedge clk) disable iff (rst)
      enable_write |=> request_enable_mask == $past(enable_wdata))
      else $error("enable register did not take written value");

   mask_hold_a: assert property (@(posedge clk) disable iff (rst)
      (clear_status_command || preset_command) && !enable_write |=> $stable(request_enable_mask))
      else $error("clear or preset changed the enable register");

   rise_request_a: assert property (@(posedge clk) disable iff (rst)
      rise |=> service_request)
      else $error("rising enabled bit did not raise a request");

   poll_clears_a: assert property (@(posedge clk) disable iff (rst)
      s_poll |-> s_req_cleared)
      else $error("serial poll did not clear the request");

   poll_byte_a: assert property (@(posedge clk) disable iff (rst)
      serial_poll |=> poll_valid && poll_byte[sbsr_pkg::BIT_RQS] == $past(service_request))
      else $error("poll byte B6 is not the request flag");

   query_byte_a: assert property (@(posedge clk) disable iff (rst)
      status_byte_query |=> query_valid && query_byte == $past(summary_status_byte))
      else $error("query byte differs from status byte");

   poll_master_a: assert property (@(posedge clk) disable iff (rst)
      serial_poll && master_now |=> master_summary)
      else $error("serial poll cleared master summary");

   ////////////////////////////////////////////////////////////////////////////
   // Reset checks carry no reset disable, so they look at the reset cycles themselves
   sequence s_quiet;
      !rise && !serial_poll;
   endsequence

   sequence s_request_held;
      ##1 $stable(service_request);
   endsequence

   sequence s_poll_then_rise;
      serial_poll ##1 rise;
   endsequence

   mask_reset_a: assert property (@(posedge clk)
      rst |=> request_enable_mask == sbsr_pkg::ENABLE_RESET)
      else $error("enable register not cleared by reset");

   byte_reset_a: assert property (@(posedge clk)
      rst |=> summary_status_byte == 8'h00 && !service_request && !master_summary)
      else $error("status byte or request not cleared by reset");

   answer_reset_a: assert property (@(posedge clk)
      rst |=> !poll_valid && !query_valid && poll_byte == 8'h00 && query_byte == 8'h00)
      else $error("answers not cleared by reset");

   meas_bit_a: assert property (@(posedge clk) disable iff (rst)
      ##1 summary_status_byte[sbsr_pkg::BIT_MEAS] == $past(set_summary[0]))
      else $error("measurement bit does not follow its summary");

   ques_bit_a: assert property (@(posedge clk) disable iff (rst)
      ##1 summary_status_byte[sbsr_pkg::BIT_QUES] == $past(set_summary[1]))
      else $error("questionable bit does not follow its summary");

   std_bit_a: assert property (@(posedge clk) disable iff (rst)
      ##1 summary_status_byte[sbsr_pkg::BIT_STD] == $past(set_summary[2]))
      else $error("standard event bit does not follow its summary");

   oper_bit_a: assert property (@(posedge clk) disable iff (rst)
      ##1 summary_status_byte[sbsr_pkg::BIT_OPER] == $past(set_summary[3]))
      else $error("operation bit does not follow its summary");

   std_falls_a: assert property (@(posedge clk) disable iff (rst)
      !set_summary[2] |=> !summary_status_byte[sbsr_pkg::BIT_STD])
      else $error("standard event bit stayed after its summary cleared");

   err_falls_a: assert property (@(posedge clk) disable iff (rst)
      summary_status_byte[sbsr_pkg::BIT_ERR] && !error_available |=> !summary_status_byte[sbsr_pkg::BIT_ERR])
      else $error("error available bit latched");

   master_track_a: assert property (@(posedge clk) disable iff (rst)
      ##1 master_summary == $past(master_now))
      else $error("master summary does not follow enabled bits");

   req_hold_a: assert property (@(posedge clk) disable iff (rst)
      s_quiet |-> s_request_held)
      else $error("request changed with no rise and no poll");

   poll_rise_wins_a: assert property (@(posedge clk) disable iff (rst)
      serial_poll && rise |=> service_request)
      else $error("poll cleared a request raised in the same cycle");

   repoll_request_a: assert property (@(posedge clk) disable iff (rst)
      s_poll_then_rise |=> service_request)
      else $error("no new request after a poll");

   rose_master_a: assert property (@(posedge clk) disable iff (rst)
      $rose(service_request) |-> master_summary)
      else $error("request rose without master summary");

   poll_rest_a: assert property (@(posedge clk) disable iff (rst)
      serial_poll |=> poll_byte[5:0] == $past(summary_status_byte[5:0])
         && poll_byte[7] == $past(summary_status_byte[7]))
      else $error("poll byte summary bits differ from status byte");

   query_master_a: assert property (@(posedge clk) disable iff (rst)
      status_byte_query |=> query_byte[sbsr_pkg::BIT_RQS] == $past(master_summary))
      else $error("query byte B6 is not the master summary");

   poll_keep_a: assert property (@(posedge clk) disable iff (rst)
      !serial_poll |=> $stable(poll_byte))
      else $error("poll byte changed without a poll");

   query_keep_a: assert property (@(posedge clk) disable iff (rst)
      !status_byte_query |=> $stable(query_byte))
      else $error("query byte changed without a query");

   poll_pulse_a: assert property (@(posedge clk) disable iff (rst)
      !serial_poll |=> !poll_valid)
      else $error("poll valid without a poll");

   query_pulse_a: assert property (@(posedge clk) disable iff (rst)
      !status_byte_query |=> !query_valid)
      else $error("query valid without a query");

   mask_keep_a: assert property (@(posedge clk) disable iff (rst)
      !enable_write |=> $stable(request_enable_mask))
      else $error("enable register changed without a write");

   unused_answer_a: assert property (@(posedge clk) disable iff (rst)
      poll_byte[sbsr_pkg::BIT_UNUSED] == 1'b0 && query_byte[sbsr_pkg::BIT_UNUSED] == 1'b0)
      else $error("unused bit one set in an answer");

   b6_mask_only_a: assert property (@(posedge clk) disable iff (rst)
      request_enable_mask == 8'h40 |=> !master_summary)
      else $error("enable bit six fed the master summary");

   no_mask_quiet_a: assert property (@(posedge clk) disable iff (rst)
      request_enable_mask == 8'h00 && !service_request |=> !service_request)
      else $error("request raised with nothing enabled");

endmodule

// ==== verif/sbsr_ctrl_model.sv ====
module sbsr_ctrl_model (
   input wire logic clk,
   input wire logic [7:0] poll_byte,
   input wire logic poll_valid,
   input wire logic [7:0] query_byte,
   input wire logic query_valid,
   output logic serial_poll,
   output logic status_byte_query,
   output logic enable_write,
   output logic [7:0] enable_wdata,
   output logic clear_status_command,
   output logic preset_command
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {serial_poll, status_byte_query, enable_write, clear_status_command, preset_command} = 5'h00;
      enable_wdata = 8'h00;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic write_mask(input logic [7:0] v);
      @(posedge clk);
      #1 enable_write = 1;
      enable_wdata = v;
      @(posedge clk);
      // Released data is inverted so a stale value cannot pass for a fresh one
      #1 enable_write = 0;
      enable_wdata = ~v;
   endtask
   task automatic clear_and_preset;
      @(posedge clk);
      #1 {clear_status_command, preset_command} = 2'h3;
      @(posedge clk);
      #1 {clear_status_command, preset_command} = 2'h0;
   endtask
   task automatic poll(output logic [7:0] b, output logic ok);
      @(posedge clk);
      #1 serial_poll = 1;
      @(posedge clk);
      #1 serial_poll = 0;
      ok = poll_valid;
      b = poll_byte;
   endtask
   task automatic query(output logic [7:0] b, output logic ok);
      @(posedge clk);
      #1 status_byte_query = 1;
      @(posedge clk);
      #1 status_byte_query = 0;
      ok = query_valid;
      b = query_byte;
   endtask
endmodule

// ==== verif/testbench.sv ====
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst = 1, error_available = 0, message_available = 0, ok;
   sbsr_pkg::sbsr_evset_t sets [4] = '{default: '0};
   logic serial_poll, status_byte_query, enable_write, clear_status_command, preset_command;
   logic master_summary, service_request, poll_valid, query_valid;
   logic [7:0] enable_wdata, request_enable_mask, summary_status_byte, poll_byte, query_byte, b;
   int n_mismatch = 0, n_tests = 0, cycles = 0;
   always #25 clk = ~clk;
   sbsr_status_byte dut (.clk, .rst, .meas_set(sets[0]), .ques_set(sets[1]), .std_set(sets[2]),
      .oper_set(sets[3]), .error_available, .message_available, .enable_write, .enable_wdata,
      .clear_status_command, .preset_command, .status_byte_query, .serial_poll, .request_enable_mask,
      .summary_status_byte, .master_summary, .service_request, .poll_byte, .poll_valid, .query_byte,
      .query_valid);
   sbsr_ctrl_model ctl (.clk, .poll_byte, .poll_valid, .query_byte, .query_valid, .serial_poll,
      .status_byte_query, .enable_write, .enable_wdata, .clear_status_command, .preset_command);
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask
   task automatic settle;
      repeat (3) @(posedge clk);
      #1;
   endtask
   task automatic stop_test;
      $display("comparisons %0d, mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Source 0..3 are event sets, 4 the output queue, 5 the error queue
   task automatic drive_src(input int i, input logic ev, input logic en);
      if (i < 4) sets[i] = {15'h0, ev, 15'h0, en};
      else if (i == 4) message_available = ev;
      else error_available = ev;
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic test_reset;
      check(request_enable_mask, 8'h00, "mask after reset");
      check(summary_status_byte, 8'h00, "byte after reset");
      check({6'h00, master_summary, service_request}, 8'h00, "request after reset");
      $display("test reset done");
   endtask
   task automatic test_mask;
      logic [7:0] vals [4] = '{8'hff, 8'ha5, 8'h5a, 8'h00};
      foreach (vals[i]) begin
         ctl.write_mask(vals[i]);
         check(request_enable_mask, vals[i], "mask readback");
      end
      ctl.write_mask(8'hc3);
      ctl.clear_and_preset();
      check(request_enable_mask, 8'hc3, "mask kept by clear/preset");
      ctl.write_mask(8'h00);
      $display("test mask done");
   endtask
   task automatic test_sources;
      int pos [6] = '{sbsr_pkg::BIT_MEAS, sbsr_pkg::BIT_QUES, sbsr_pkg::BIT_STD, sbsr_pkg::BIT_OPER,
         sbsr_pkg::BIT_MSG, sbsr_pkg::BIT_ERR};
      for (int i = 0; i < 6; i++) begin
         drive_src(i, i < 4, 1'h0);
         settle();
         check(summary_status_byte, 8'h00, "disabled event shows");
         drive_src(i, 1, 1);
         settle();
         check(summary_status_byte, 8'h01 << pos[i], "summary bit position");
         drive_src(i, 0, 1);
         settle();
         check(summary_status_byte, 8'h00, "summary bit latched");
      end
      $display("test sources done");
   endtask
   task automatic test_request;
      ctl.write_mask(8'h04);
      error_available = 1;
      settle();
      check({7'h0, service_request}, 8'h01, "no service request");
      ctl.query(b, ok);
      check(b, 8'h44, "query byte");
      check({7'h0, ok}, 8'h01, "no query answer");
      ctl.poll(b, ok);
      check(b, 8'h44, "poll byte");
      check({7'h0, ok}, 8'h01, "no poll answer");
      #1 check({7'h0, service_request}, 8'h00, "request not cleared by poll");
      ctl.query(b, ok);
      check(b, 8'h44, "master cleared by poll");
      error_available = 0;
      settle();
      ctl.query(b, ok);
      check(b, 8'h00, "master stuck");
      error_available = 1;
      settle();
      check({7'h0, service_request}, 8'h01, "no request after poll");
      ctl.poll(b, ok);
      check(b, 8'h44, "second poll byte");
      error_available = 0;
      $display("test request done");
   endtask
   task automatic test_ignored_bits;
      ctl.write_mask(8'h42);
      error_available = 1;
      settle();
      check({7'h0, master_summary}, 8'h00, "bit 6 or 1 feeds master");
      ctl.query(b, ok);
      check(b, 8'h04, "query with unused bits");
      error_available = 0;
      $display("test ignored bits done");
   endtask
   ////////////////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_mismatch++;
         stop_test();
      end
   end
   initial begin
      repeat (2) @(posedge clk);
      #1 rst = 0;
      test_reset();
      test_mask();
      test_sources();
      test_request();
      test_ignored_bits();
      stop_test();
   end
endmodule
